// file: core/stxe_pkg.sv
// stxe_pkg: constants, types and decode helpers for the execution block
// Summary of operation
// RQ1 - test zero: discard and idle the next word
// RQ2 - a=0 access bank, a=1 bank select
// RQ3 - extended, a=0, f<=95: indexed offset address
// RQ4 - test skip takes one, two or three cycles
// RQ5 - xor literal into accumulator in one cycle
// RQ6 - xor file; d picks accumulator or file
// RQ7 - xor file updates only negative and zero
// RQ8 - extended set off until enable bit set
// RQ9 - decode eight extra instructions when enabled
// RQ10 - extended add/sub ops are pointer literal operations
// RQ11 - third-pointer add/sub variants then return
// RQ12 - table write second cycle loads holding register
package stxe_pkg;
    localparam int FSR_W = 12;
    localparam int PTR_W = 22;
    localparam int FSR_N = 3;
    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_BSR = 12'h004;
    localparam logic [11:0] OFF_W = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_TABLE_LATCH = 12'h010;
    localparam logic [11:0] OFF_TABLE_POINTER = 12'h014;
    localparam logic [11:0] OFF_FSR0 = 12'h018;
    localparam logic [11:0] OFF_DADDR = 12'h024;
    localparam logic [11:0] OFF_DDATA = 12'h028;
    localparam logic [11:0] OFF_EXEC = 12'h02C;
    localparam logic [11:0] REG_STRIDE = 12'h004;
    // opcode fields
    localparam logic [6:0] OPC_TST = 7'h33;
    localparam logic [5:0] OPC_XWF = 6'h06;
    localparam logic [7:0] OPC_XLW = 8'h0A;
    localparam logic [13:0] OPC_TBLW = 14'h0003;
    localparam logic [7:0] OPC_ADDF = 8'hE8;
    localparam logic [7:0] OPC_SUBF = 8'hE9;
    localparam logic [7:0] OPC_PUSHL = 8'hEA;
    localparam logic [7:0] OPC_MOVS = 8'hEB;
    localparam logic [15:0] OPC_CALLW = 16'h0014;
    localparam logic [3:0] OPC_MOVFF = 4'hC;
    localparam logic [6:0] OPC_CALL = 7'h76;
    localparam logic [7:0] OPC_LFSR = 8'hEE;
    localparam logic [7:0] OPC_GOTO = 8'hEF;
    localparam logic [7:0] ILO_MAX = 8'h5F;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hF;
    localparam logic [1:0] FSR_RET_SEL = 2'h3;
    localparam logic [1:0] FSR_TWO = 2'h2;
    localparam logic [1:0] TB_POSTINC = 2'h1;
    localparam logic [1:0] TB_POSTDEC = 2'h2;
    localparam logic [1:0] TB_PREINC = 2'h3;
    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} stxe_q_t;
    typedef enum logic [3:0] {K_NONE, K_NOP, K_SKIP, K_TST, K_XLW, K_XWF,
        K_TBLW, K_TBL2, K_FSR, K_RET2, K_EXT} stxe_kind_t;
    typedef enum logic [3:0] {EX_NONE, EX_ADD_LITERAL_TO_POINTER_OP, EX_ADD_POINTER_AND_RETURN_OP, EX_CALLW,
        EX_MOVSF, EX_MOVSS, EX_PUSHL, EX_SUB_LITERAL_FROM_POINTER_OP, EX_SUB_POINTER_AND_RETURN_OP} stxe_ext_t;
    function automatic logic is_two_word(input logic [15:0] w, input logic ext);
        return (w[15:12] == OPC_MOVFF) || (w[15:9] == OPC_CALL) ||
            (w[15:8] == OPC_LFSR) || (w[15:8] == OPC_GOTO) ||
            (ext && w[15:8] == OPC_MOVS);
    endfunction
endpackage

// file: core/stxe_mem_if.sv
// stxe_mem_if: data memory ports for execution and software access
`timescale 1ns/1ps
`default_nettype none
interface stxe_mem_if;
    logic [11:0] addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [11:0] sw_addr;
    logic sw_we;
    logic [7:0] sw_wdata;
    logic [7:0] sw_rdata;
    modport core (output addr, we, wdata, sw_addr, sw_we, sw_wdata, input rdata, sw_rdata);
    modport mem (input addr, we, wdata, sw_addr, sw_we, sw_wdata, output rdata, sw_rdata);
endinterface
`default_nettype wire

// file: core/stxe_dmem.sv
// stxe_dmem: data register file with an execution port and a software port
`timescale 1ns/1ps
`default_nettype none
module stxe_dmem #(
    parameter int DEPTH = 4096
) (
    // clock
    input wire logic pclk,
    // ports
    stxe_mem_if.mem m
);
    logic [7:0] mem_q [DEPTH];

    assign m.rdata = mem_q[m.addr];
    assign m.sw_rdata = mem_q[m.sw_addr];

    // a software data write is stalled while execution writes, so the two never meet
    always_ff @(posedge pclk) begin
        if (m.we) begin
            mem_q[m.addr] <= m.wdata;
        end else if (m.sw_we) begin
            mem_q[m.sw_addr] <= m.sw_wdata;
        end
    end
endmodule
`default_nettype wire

// file: core/stxe_addr_gen.sv
// stxe_addr_gen: effective data address for file register operands
`timescale 1ns/1ps
`default_nettype none
module stxe_addr_gen (
    // operand fields
    input wire logic [7:0] f,
    input wire logic a,
    // addressing state
    input wire logic ext_en,
    input wire logic [3:0] bank_select_reg,
    input wire logic [11:0] file_select_pointer_two,
    // result
    output logic [11:0] ea,
    output logic ilo
);
    wire logic low_half = f <= stxe_pkg::ILO_MAX;
    wire logic [11:0] idx_addr = file_select_pointer_two + {4'h0, f};
    wire logic [11:0] acc_addr = low_half ? {stxe_pkg::ACC_LO_BANK, f} : {stxe_pkg::ACC_HI_BANK, f};

    assign ilo = !a && ext_en && low_half; // [RQ3]
    assign ea = ilo ? idx_addr : (a ? {bank_select_reg, f} : acc_addr); // [RQ2]
endmodule
`default_nettype wire

// file: core/stxe_core.sv
// stxe_core: executes test-skip, xor, table write tail and pointer literal ops
`timescale 1ns/1ps
`default_nettype none
module stxe_core #(
    parameter int PTR_W = 22,
    parameter int DEPTH = 4096
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    // return request and holding register write
    output logic ret_pulse,
    output logic hold_we,
    output logic [PTR_W-1:0] hold_addr,
    output logic [7:0] hold_data
);
    stxe_pkg::stxe_q_t ph_q;
    stxe_pkg::stxe_kind_t kind_q;
    stxe_pkg::stxe_kind_t pend_q;
    stxe_pkg::stxe_kind_t dec_kind;
    stxe_pkg::stxe_ext_t ext_code_q;
    stxe_pkg::stxe_ext_t dec_ext;
    logic [15:0] ir_q;
    logic [7:0] w_q;
    logic [7:0] opnd_q;
    logic [7:0] res_q;
    logic [7:0] table_latch_q;
    logic [4:0] status_q;
    logic [3:0] bsr_q;
    logic ext_q;
    logic skip_q;
    logic [stxe_pkg::FSR_W-1:0] fsr_q [stxe_pkg::FSR_N];
    logic [PTR_W-1:0] table_pointer_q;
    logic [11:0] daddr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    logic ret_q;
    logic hold_we_q;
    logic [PTR_W-1:0] hold_addr_q;
    logic [7:0] hold_data_q;
    logic [11:0] ea;
    logic ilo;

    stxe_mem_if mif ();

    function automatic stxe_pkg::stxe_ext_t ext_dec(input logic [15:0] w);
        stxe_pkg::stxe_ext_t e;
        logic ret;
        e = stxe_pkg::EX_NONE;
        ret = w[7:6] == stxe_pkg::FSR_RET_SEL;
        if (w[15:8] == stxe_pkg::OPC_ADDF) begin
            e = ret ? stxe_pkg::EX_ADD_POINTER_AND_RETURN_OP : stxe_pkg::EX_ADD_LITERAL_TO_POINTER_OP;
        end else if (w[15:8] == stxe_pkg::OPC_SUBF) begin
            e = ret ? stxe_pkg::EX_SUB_POINTER_AND_RETURN_OP : stxe_pkg::EX_SUB_LITERAL_FROM_POINTER_OP;
        end else if (w[15:8] == stxe_pkg::OPC_PUSHL) begin
            e = stxe_pkg::EX_PUSHL;
        end else if (w[15:8] == stxe_pkg::OPC_MOVS) begin
            e = w[7] ? stxe_pkg::EX_MOVSS : stxe_pkg::EX_MOVSF;
        end else if (w == stxe_pkg::OPC_CALLW) begin
            e = stxe_pkg::EX_CALLW;
        end
        return e;
    endfunction

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // phase and sequencing
    wire logic is_q1 = ph_q == stxe_pkg::PH_Q1;
    wire logic is_q2 = ph_q == stxe_pkg::PH_Q2;
    wire logic is_q3 = ph_q == stxe_pkg::PH_Q3;
    wire logic is_q4 = ph_q == stxe_pkg::PH_Q4;
    wire logic has_pend = pend_q != stxe_pkg::K_NONE;
    assign instr_ready = is_q1 && !has_pend;
    wire logic take = instr_ready && instr_valid;
    wire logic adv = !is_q1 || take || has_pend;
    wire logic two_word = stxe_pkg::is_two_word(instr_word, ext_q);

    // extended forms only exist with the enable bit set
    assign dec_ext = ext_q ? ext_dec(instr_word) : stxe_pkg::EX_NONE; // [RQ8] [RQ9]
    wire logic ext_fsr = dec_ext inside {stxe_pkg::EX_ADD_LITERAL_TO_POINTER_OP, stxe_pkg::EX_ADD_POINTER_AND_RETURN_OP,
        stxe_pkg::EX_SUB_LITERAL_FROM_POINTER_OP, stxe_pkg::EX_SUB_POINTER_AND_RETURN_OP};
    assign dec_kind = (instr_word[15:9] == stxe_pkg::OPC_TST) ? stxe_pkg::K_TST :
        (instr_word[15:10] == stxe_pkg::OPC_XWF) ? stxe_pkg::K_XWF :
        (instr_word[15:8] == stxe_pkg::OPC_XLW) ? stxe_pkg::K_XLW :
        (instr_word[15:2] == stxe_pkg::OPC_TBLW) ? stxe_pkg::K_TBLW :
        ext_fsr ? stxe_pkg::K_FSR :
        (dec_ext != stxe_pkg::EX_NONE) ? stxe_pkg::K_EXT : stxe_pkg::K_NOP;

    // execution strobes
    wire logic is_xwf = kind_q == stxe_pkg::K_XWF;
    wire logic is_xlw = kind_q == stxe_pkg::K_XLW;
    wire logic core_we = is_q4 && is_xwf && ir_q[9]; // [RQ6]
    wire logic w_upd = is_q4 && (is_xlw || (is_xwf && !ir_q[9])); // [RQ5] [RQ6]
    wire logic flag_upd = is_q4 && (is_xlw || is_xwf);
    wire logic tbl1 = is_q4 && kind_q == stxe_pkg::K_TBLW;
    wire logic tbl2 = is_q4 && kind_q == stxe_pkg::K_TBL2;
    wire logic fsr_upd = is_q4 && kind_q == stxe_pkg::K_FSR;
    wire logic fsr_ret = ir_q[7:6] == stxe_pkg::FSR_RET_SEL;
    wire logic [1:0] fsr_sel = fsr_ret ? stxe_pkg::FSR_TWO : ir_q[7:6]; // [RQ11]
    wire logic [11:0] fsr_k = {6'h00, ir_q[5:0]};
    // a 6-bit literal added to or taken from the chosen pointer
    wire logic [11:0] fsr_new = ir_q[8] ? fsr_q[fsr_sel] - fsr_k : fsr_q[fsr_sel] + fsr_k; // [RQ10]
    wire logic [1:0] tb_mode = ir_q[1:0];

    // apb decode
    wire logic apb_setup = psel && !penable;
    wire logic apb_acc = psel && penable;
    wire logic hit_ddata = reg_hit(paddr, stxe_pkg::OFF_DDATA);
    wire logic hit_any = paddr <= stxe_pkg::OFF_EXEC && paddr[1:0] == 2'h0;
    // a software data write waits out the execution write cycle
    assign pready = !(hit_ddata && pwrite && core_we);
    assign pslverr = apb_acc && !hit_any;
    wire logic apb_wr = apb_acc && pwrite && pready && hit_any;

    stxe_addr_gen u_addr (
        .f(ir_q[7:0]),
        .a(ir_q[8]),
        .ext_en(ext_q),
        .bank_select_reg(bsr_q),
        .file_select_pointer_two(fsr_q[stxe_pkg::FSR_TWO]),
        .ea(ea),
        .ilo(ilo)
    );

    assign mif.addr = ea;
    assign mif.we = core_we;
    assign mif.wdata = res_q;
    assign mif.sw_addr = daddr_q;
    assign mif.sw_we = apb_wr && hit_ddata;
    assign mif.sw_wdata = pwdata[7:0];

    stxe_dmem #(
        .DEPTH(DEPTH)
    ) u_dmem (
        .pclk(pclk),
        .m(mif.mem)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= stxe_pkg::PH_Q1;
        end else if (adv) begin
            ph_q <= stxe_pkg::stxe_q_t'(ph_q + 2'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_q <= stxe_pkg::K_NONE;
            ir_q <= 16'h0000;
            ext_code_q <= stxe_pkg::EX_NONE;
        end else if (is_q1 && has_pend) begin
            kind_q <= pend_q;
        end else if (take) begin
            kind_q <= skip_q ? stxe_pkg::K_SKIP : dec_kind; // [RQ1]
            ir_q <= instr_word;
            if (!skip_q && dec_ext != stxe_pkg::EX_NONE) begin
                ext_code_q <= dec_ext;
            end
        end
    end

    // second cycles of table write and of the returning pointer ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= stxe_pkg::K_NONE;
        end else if (is_q1) begin
            pend_q <= stxe_pkg::K_NONE;
        end else if (tbl1) begin
            pend_q <= stxe_pkg::K_TBL2; // [RQ12]
        end else if (fsr_upd && fsr_ret) begin
            pend_q <= stxe_pkg::K_RET2; // [RQ11]
        end
    end

    // a skipped first word of a two-word op keeps the skip for its second word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_q <= 1'b0;
        end else if (take && skip_q) begin
            skip_q <= two_word; // [RQ4]
        end else if (is_q4 && kind_q == stxe_pkg::K_TST && opnd_q == 8'h00) begin
            skip_q <= 1'b1; // [RQ1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
        end else if (is_q2) begin
            opnd_q <= mif.rdata;
        end else if (is_q3) begin
            res_q <= w_q ^ (is_xlw ? ir_q[7:0] : opnd_q); // [RQ5] [RQ6]
        end
    end

    // execution writes win over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_q <= 8'h00;
        end else if (w_upd) begin
            w_q <= res_q;
        end else if (apb_wr && reg_hit(paddr, stxe_pkg::OFF_W)) begin
            w_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 5'h00;
        end else if (flag_upd) begin
            status_q[stxe_pkg::ST_N] <= res_q[7]; // [RQ7]
            status_q[stxe_pkg::ST_Z] <= res_q == 8'h00;
        end else if (apb_wr && reg_hit(paddr, stxe_pkg::OFF_STATUS)) begin
            status_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 1'b0; // [RQ8]
            bsr_q <= 4'h0;
            table_latch_q <= 8'h00;
            daddr_q <= 12'h000;
        end else if (apb_wr) begin
            if (reg_hit(paddr, stxe_pkg::OFF_CTRL)) begin
                ext_q <= pwdata[0];
            end
            if (reg_hit(paddr, stxe_pkg::OFF_BSR)) begin
                bsr_q <= pwdata[3:0];
            end
            if (reg_hit(paddr, stxe_pkg::OFF_TABLE_LATCH)) begin
                table_latch_q <= pwdata[7:0];
            end
            if (reg_hit(paddr, stxe_pkg::OFF_DADDR)) begin
                daddr_q <= pwdata[11:0];
            end
        end
    end

    for (genvar i = 0; i < stxe_pkg::FSR_N; i++) begin : g_fsr
        localparam logic [11:0] OFF = stxe_pkg::OFF_FSR0 + 12'(i) * stxe_pkg::REG_STRIDE;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fsr_q[i] <= '0;
            end else if (fsr_upd && fsr_sel == 2'(i)) begin
                fsr_q[i] <= fsr_new; // [RQ10]
            end else if (apb_wr && reg_hit(paddr, OFF)) begin
                fsr_q[i] <= pwdata[stxe_pkg::FSR_W-1:0];
            end
        end
    end

    // pre-increment in the first cycle, post-update in the second cycle as the holding address is captured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_pointer_q <= '0;
        end else if (tbl1 && tb_mode == stxe_pkg::TB_PREINC) begin
            table_pointer_q <= table_pointer_q + 1'b1;
        end else if (tbl2 && tb_mode == stxe_pkg::TB_POSTINC) begin
            table_pointer_q <= table_pointer_q + 1'b1;
        end else if (tbl2 && tb_mode == stxe_pkg::TB_POSTDEC) begin
            table_pointer_q <= table_pointer_q - 1'b1;
        end else if (apb_wr && reg_hit(paddr, stxe_pkg::OFF_TABLE_POINTER)) begin
            table_pointer_q <= pwdata[PTR_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_we_q <= 1'b0;
            hold_addr_q <= '0;
            hold_data_q <= 8'h00;
            ret_q <= 1'b0;
        end else begin
            hold_we_q <= tbl2; // [RQ12]
            ret_q <= is_q4 && kind_q == stxe_pkg::K_RET2; // [RQ11]
            if (tbl2) begin
                hold_addr_q <= table_pointer_q;
                hold_data_q <= table_latch_q;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            stxe_pkg::OFF_CTRL: rd_mux[0] = ext_q;
            stxe_pkg::OFF_BSR: rd_mux[3:0] = bsr_q;
            stxe_pkg::OFF_W: rd_mux[7:0] = w_q;
            stxe_pkg::OFF_STATUS: rd_mux[4:0] = status_q;
            stxe_pkg::OFF_TABLE_LATCH: rd_mux[7:0] = table_latch_q;
            stxe_pkg::OFF_TABLE_POINTER: rd_mux[PTR_W-1:0] = table_pointer_q;
            stxe_pkg::OFF_FSR0: rd_mux[11:0] = fsr_q[0];
            stxe_pkg::OFF_FSR0 + stxe_pkg::REG_STRIDE: rd_mux[11:0] = fsr_q[1];
            stxe_pkg::OFF_FSR0 + 12'(stxe_pkg::FSR_TWO) * stxe_pkg::REG_STRIDE: rd_mux[11:0] = fsr_q[stxe_pkg::FSR_TWO];
            stxe_pkg::OFF_DADDR: rd_mux[11:0] = daddr_q;
            stxe_pkg::OFF_DDATA: rd_mux[7:0] = mif.sw_rdata;
            stxe_pkg::OFF_EXEC: rd_mux[8:0] = {ext_code_q, ph_q, ilo, skip_q, has_pend};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata = prdata_q;
    assign ret_pulse = ret_q;
    assign hold_we = hold_we_q;
    assign hold_addr = hold_addr_q;
    assign hold_data = hold_data_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_skip_discard: assert property ( // [RQ1]
        (take && skip_q) |=> kind_q == stxe_pkg::K_SKIP)
        else $error("word after a zero test was not discarded");
    chk_skip_arm: assert property ( // [RQ1]
        (is_q4 && kind_q == stxe_pkg::K_TST && opnd_q == 8'h00) |=> skip_q)
        else $error("zero test did not arm the skip");
    chk_bank_sel: assert property ( // [RQ2]
        ((is_xwf || kind_q == stxe_pkg::K_TST) && ir_q[8]) |-> mif.addr == {bsr_q, ir_q[7:0]})
        else $error("banked operand address wrong");
    chk_ilo_addr: assert property ( // [RQ3]
        (ext_q && !ir_q[8] && ir_q[7:0] <= stxe_pkg::ILO_MAX)
        |-> mif.addr == fsr_q[stxe_pkg::FSR_TWO] + {4'h0, ir_q[7:0]})
        else $error("indexed offset address wrong");
    chk_skip_len: assert property ( // [RQ4]
        (take && skip_q) |=> skip_q == $past(two_word))
        else $error("skip length does not follow word count");
    chk_xlw_result: assert property ( // [RQ5]
        (is_q4 && is_xlw) |=> w_q == ($past(w_q) ^ ir_q[7:0]))
        else $error("xor literal result wrong");
    chk_xwf_to_w: assert property ( // [RQ6]
        (is_q3 && is_xwf && !ir_q[9]) |=> ##1 w_q == ($past(w_q, 2) ^ $past(opnd_q, 2)))
        else $error("xor file result not in accumulator");
    chk_xwf_flags: assert property ( // [RQ7]
        (is_q4 && is_xwf) |=> status_q[stxe_pkg::ST_Z] == ($past(res_q) == 8'h00)
        && status_q[stxe_pkg::ST_C] == $past(status_q[stxe_pkg::ST_C])
        && status_q[stxe_pkg::ST_DC] == $past(status_q[stxe_pkg::ST_DC])
        && status_q[stxe_pkg::ST_OV] == $past(status_q[stxe_pkg::ST_OV]))
        else $error("xor file touched wrong flags");
    chk_ext_gate: assert property ( // [RQ8]
        (take && !ext_q) |=> kind_q != stxe_pkg::K_FSR && kind_q != stxe_pkg::K_EXT)
        else $error("extended op decoded while disabled");
    chk_fsr_ret: assert property ( // [RQ11]
        (fsr_upd && fsr_ret) |-> ##5 ret_pulse)
        else $error("pointer op with return gave no return");
    chk_tbl_hold: assert property ( // [RQ12]
        tbl1 |-> ##5 hold_we)
        else $error("table write gave no holding write");

    cov_skip_two: cover property (take && skip_q && two_word ##1 skip_q);
    cov_xwf_file: cover property (core_we);
    cov_ret: cover property (ret_pulse);
    cov_tbl: cover property (hold_we);
endmodule
`default_nettype wire

// file: tb/stxe_fetch_model.sv
// stxe_fetch_model: program memory stream feeding instruction words
`timescale 1ns/1ps
`default_nettype none
module stxe_fetch_model (
    // clock and pacing
    input wire logic pclk,
    input wire logic slow,
    // instruction stream
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [15:0] instr_word
);
    logic [15:0] q[$];
    logic tick;
    initial begin
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        tick = 1'b0;
    end
    // an offered word stays put until taken; the idle bus flips so stale words never look valid
    always @(posedge pclk) begin
        if (instr_valid && instr_ready)
            void'(q.pop_front());
        tick = ~tick;
        if (instr_valid && !instr_ready) begin
        end else if (q.size() != 0 && (!slow || tick)) begin
            instr_valid <= 1'b1;
            instr_word <= q[0];
        end else begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
        end
    end
endmodule
`default_nettype wire

// file: tb/skip_test_xor_and_ext_set_exec_bench.sv
// skip_test_xor_and_ext_set_exec_bench: self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
module skip_test_xor_and_ext_set_exec_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic instr_valid, instr_ready, ret_pulse, hold_we;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] instr_word;
    logic [21:0] hold_addr;
    logic [7:0] hold_data, e, k;
    logic [32:0] rd_q[$];
    logic [29:0] hd_q[$];
    int bad_count, cmp_count, ret_n, i;
    integer seed;
    stxe_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
        .ret_pulse(ret_pulse), .hold_we(hold_we), .hold_addr(hold_addr), .hold_data(hold_data));
    stxe_fetch_model fm (.pclk(pclk), .slow(slow), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr_word(instr_word));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            bad_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] exp);
        rd_q.push_back(exp);
        apb(1'b0, a, 32'h00000000);
    endtask
    task op(input logic [15:0] w);
        fm.q.push_back(w);
    endtask
    // wait until the stream is drained and the core is back in its first phase
    task settle;
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge pclk);
            #1;
            if (fm.q.size() == 0 && !instr_valid && instr_ready === 1'b1)
                break;
        end
        if (n == 400)
            bad_count++;
    endtask
    // watcher: every completed read or holding write retires the oldest noted expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check("apb read", {7'h00, pslverr, prdata}, {7'h00, rd_q.pop_front()});
        if (hold_we === 1'b1)
            check("holding write", {10'h000, hold_addr, hold_data}, {10'h000, hd_q.pop_front()});
        if (ret_pulse === 1'b1)
            ret_n++;
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        seed = 32'h1ED3;
        {presetn, psel, penable, pwrite, slow} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(stxe_pkg::OFF_CTRL, 33'h000000000);
        rd(12'h030, 33'h100000000);
        wr(stxe_pkg::OFF_W, 32'hB5);
        wr(stxe_pkg::OFF_STATUS, 32'h0B);
        op(16'h0AAF);
        settle();
        rd(stxe_pkg::OFF_W, 33'h1A);
        rd(stxe_pkg::OFF_STATUS, 33'h0B);
        slow <= 1'b1;
        e = 8'h1A;
        for (i = 0; i < 4; i++) begin
            k = 8'($random(seed));
            e = e ^ k;
            op({8'h0A, k});
        end
        settle();
        rd(stxe_pkg::OFF_W, {25'h0, e});
        rd(stxe_pkg::OFF_STATUS, {28'h0, e[7], 1'b1, e == 8'h00, 2'h3});
        wr(stxe_pkg::OFF_BSR, 32'h1);
        wr(stxe_pkg::OFF_DADDR, 32'h1AA);
        wr(stxe_pkg::OFF_DDATA, 32'hAF);
        wr(stxe_pkg::OFF_W, 32'hB5);
        op(16'h1BAA);
        settle();
        rd(stxe_pkg::OFF_DDATA, 33'h1A);
        rd(stxe_pkg::OFF_W, 33'hB5);
        op(16'h19AA);
        settle();
        rd(stxe_pkg::OFF_W, 33'hAF);
        rd(stxe_pkg::OFF_STATUS, 33'h1B);
        wr(stxe_pkg::OFF_DADDR, 32'hFF0);
        wr(stxe_pkg::OFF_DDATA, 32'hFF);
        op(16'h1AF0);
        settle();
        rd(stxe_pkg::OFF_DDATA, 33'h50);
        // zero test: the following word, and both words of a two-word op, are dropped
        wr(stxe_pkg::OFF_DADDR, 32'h1AA);
        wr(stxe_pkg::OFF_DDATA, 32'h00);
        op(16'h67AA);
        op(16'h0AFF);
        op(16'h0A0F);
        op(16'h67AA);
        op(16'hEF12);
        op(16'hF034);
        op(16'h0A01);
        settle();
        rd(stxe_pkg::OFF_W, 33'hA1);
        wr(stxe_pkg::OFF_DDATA, 32'h05);
        op(16'h67AA);
        op(16'h0A10);
        settle();
        rd(stxe_pkg::OFF_W, 33'hB1);
        wr(stxe_pkg::OFF_FSR0, 32'h100);
        op(16'hE805);
        settle();
        rd(stxe_pkg::OFF_FSR0, 33'h100);
        wr(stxe_pkg::OFF_CTRL, 32'h1);
        wr(stxe_pkg::OFF_FSR0 + 12'h008, 32'h3FF);
        op(16'hE805);
        op(16'hE8E3);
        op(16'hE9C1);
        settle();
        rd(stxe_pkg::OFF_FSR0, 33'h105);
        rd(stxe_pkg::OFF_FSR0 + 12'h008, 33'h421);
        check("return requests", 40'(ret_n), 40'h2);
        // a push-literal op is recorded in the exec word and runs as a no-op here
        op(16'hEA05);
        settle();
        rd(stxe_pkg::OFF_EXEC, 33'h0C4);
        wr(stxe_pkg::OFF_FSR0 + 12'h008, 32'h200);
        wr(stxe_pkg::OFF_DADDR, 32'h210);
        wr(stxe_pkg::OFF_DDATA, 32'h0F);
        op(16'h1A10);
        settle();
        rd(stxe_pkg::OFF_DDATA, 33'hBE);
        wr(stxe_pkg::OFF_TABLE_LATCH, 32'h55);
        wr(stxe_pkg::OFF_TABLE_POINTER, 32'hA356);
        hd_q.push_back({22'h00A356, 8'h55});
        op(16'h000D);
        settle();
        rd(stxe_pkg::OFF_TABLE_POINTER, 33'hA357);
        wr(stxe_pkg::OFF_TABLE_LATCH, 32'h34);
        wr(stxe_pkg::OFF_TABLE_POINTER, 32'h1389A);
        hd_q.push_back({22'h01389B, 8'h34});
        op(16'h000F);
        settle();
        rd(stxe_pkg::OFF_TABLE_POINTER, 33'h1389B);
        hd_q.push_back({22'h01389B, 8'h34});
        op(16'h000E);
        settle();
        rd(stxe_pkg::OFF_TABLE_POINTER, 33'h1389A);
        check("holding writes left", 40'(hd_q.size()), 40'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
